/* hdl/dbd_pkg.sv */
// Constants and register map of the bankset decode block
// How it works
// - Upper presence register shows serial presence bits 31 to 16.
// - Presence data is flagged valid only 148 clocks after reset release.
// - Every bus address is compared against each bankset base address.
// - A base address decodes only while its bankset valid bit is set.
// - Reset clears only valid and subbank enable; other fields stay undefined.
// - Valid bit 0 resets low; clear valid refuses access to the bankset.
package dbd_pkg;
  localparam int NUM_SETS = 8;
  localparam int SET_W = 3;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PHYS_ADDR_W = 34;
  localparam int BASE_W = 11;
  localparam int BASE_LSB = 23;
  localparam int SUB_TOP = 29;
  localparam int CFG_W = 16;
  localparam int CFG_VALID_BIT = 0;
  localparam int CFG_SIZE_LSB = 1;
  localparam int CFG_SIZE_W = 4;
  localparam int CFG_SUBENA_BIT = 5;
  localparam logic [3:0] SIZE_MIN = 4'h1;
  localparam logic [3:0] SIZE_MAX = 4'h7;
  localparam logic CFG_VALID_RST = 1'b0;
  localparam logic CFG_SUBENA_RST = 1'b0;
  localparam int PD_BITS = 32;
  localparam int PD_HALF = 16;
  localparam int PD_CNT_W = 8;
  localparam logic [7:0] PD_VALID_CYCLES = 8'h94;
  localparam logic [ADDR_W-1:0] OFS_PD_LOW = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_PD_HIGH = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_SET_BASE0 = 12'h040;
  localparam logic [ADDR_W-1:0] OFS_SET_CFG0 = 12'h044;
  localparam logic [ADDR_W-1:0] SET_STRIDE = 12'h008;
  localparam int STAT_PD_VALID_BIT = 0;
  localparam int STAT_HIT_BIT = 1;
  localparam int STAT_SET_LSB = 2;
endpackage

/* hdl/dbd_presence.sv */
// Presence-detect serial capture after reset
`timescale 1ns/10ps
module dbd_presence (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // Serial presence pin
  input wire logic presence_serial_i,
  // Captured word
  output logic [dbd_pkg::PD_BITS-1:0] pd_data_o,
  output logic pd_valid_o
);
  import dbd_pkg::*;

  logic sync_a;
  logic sync_b;
  logic [PD_CNT_W-1:0] cnt;
  logic [PD_CNT_W-1:0] next_cnt;
  logic [PD_BITS-1:0] next_pd_data;
  logic next_pd_valid;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else if (ce_i) begin
      sync_a <= presence_serial_i;
      sync_b <= sync_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cnt = cnt;
    next_pd_data = pd_data_o;
    next_pd_valid = pd_valid_o;
    if (cnt != PD_VALID_CYCLES) begin
      next_cnt = cnt + 8'h01;
    end
    // Bits arrive LSB first during the first word time
    if (cnt < 8'(PD_BITS)) begin
      next_pd_data = {sync_b, pd_data_o[PD_BITS-1:1]};
    end
    if (next_cnt == PD_VALID_CYCLES) begin
      next_pd_valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= '0;
      pd_data_o <= '0;
      pd_valid_o <= 1'b0;
    end else if (ce_i) begin
      cnt <= next_cnt;
      pd_data_o <= next_pd_data;
      pd_valid_o <= next_pd_valid;
    end
  end
endmodule // dbd_presence

/* hdl/dbd_decode.sv */
// Bankset address decode with APB configuration registers
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/10ps
module dbd_decode (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [dbd_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [dbd_pkg::DATA_W-1:0] pwdata_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [dbd_pkg::DATA_W-1:0] prdata_o,
  // System bus address
  input wire logic address_valid_i,
  input wire logic [dbd_pkg::PHYS_ADDR_W-1:0] system_bus_address_i,
  input wire logic refresh_i,
  // Decode result
  output logic hit_o,
  output logic refused_o,
  output logic [dbd_pkg::SET_W-1:0] hit_set_o,
  output logic subbank_o,
  output logic [dbd_pkg::NUM_SETS-1:0] subbank_row_strobe_n_o,
  // Presence pin
  input wire logic presence_serial_i
);
  import dbd_pkg::*;

  typedef enum logic [1:0] {
    DBD_KIND_NONE = 2'b01,
    DBD_KIND_MAP = 2'b10
  } dbd_kind_t;

  logic [PD_BITS-1:0] pd_data;
  logic pd_valid;
  logic set_valid [NUM_SETS];
  logic subbank_enable [NUM_SETS];
  logic [CFG_SIZE_W-1:0] set_size_code [NUM_SETS];
  logic [BASE_W-1:0] set_base [NUM_SETS];
  logic next_set_valid [NUM_SETS];
  logic next_subbank_enable [NUM_SETS];
  logic [CFG_SIZE_W-1:0] next_set_size_code [NUM_SETS];
  logic [BASE_W-1:0] next_set_base [NUM_SETS];
  logic [NUM_SETS-1:0] set_match;
  logic [NUM_SETS-1:0] set_subbit;
  logic next_pready;
  logic next_pslverr;
  logic [DATA_W-1:0] next_prdata;
  logic next_hit;
  logic next_refused;
  logic [SET_W-1:0] next_hit_set;
  logic next_subbank;
  logic [NUM_SETS-1:0] next_strobe_n;
  logic apb_write;
  dbd_kind_t rd_kind;

  dbd_presence u_presence (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .presence_serial_i(presence_serial_i),
    .pd_data_o(pd_data),
    .pd_valid_o(pd_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [BASE_W-1:0] size_mask(input logic [CFG_SIZE_W-1:0] code);
    // Code 1 compares the top 5 bits, code 7 all 11
    size_mask = 11'h7FF << 3'(SIZE_MAX - code);
  endfunction

  function automatic logic size_legal(input logic [CFG_SIZE_W-1:0] code);
    size_legal = (code >= SIZE_MIN) && (code <= SIZE_MAX);
  endfunction

  function automatic logic is_set_reg(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] first, input int idx);
    is_set_reg = (a == first + 12'(idx) * SET_STRIDE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Per-set compare
  for (genvar s = 0; s < NUM_SETS; s++) begin : g_set
    always_comb begin
      // Reserved sizes never match, so a bad code cannot alias a set
      set_match[s] = set_valid[s] && size_legal(set_size_code[s]) &&
                     (((system_bus_address_i[PHYS_ADDR_W-1:BASE_LSB] ^ set_base[s]) &
                       size_mask(set_size_code[s])) == '0);
      set_subbit[s] = system_bus_address_i[SUB_TOP - int'(set_size_code[s][2:0])];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode result; lowest set wins if software overlaps two
  always_comb begin
    next_hit = hit_o;
    next_refused = refused_o;
    next_hit_set = hit_set_o;
    next_subbank = subbank_o;
    if (address_valid_i) begin
      next_hit = |set_match;
      next_refused = ~(|set_match);
      next_hit_set = '0;
      next_subbank = 1'b0;
      for (int s = NUM_SETS - 1; s >= 0; s--) begin
        if (set_match[s]) begin
          next_hit_set = SET_W'(s);
          next_subbank = subbank_enable[s] & set_subbit[s];
        end
      end
    end
    for (int s = 0; s < NUM_SETS; s++) begin
      // Without subbank enable the strobe only serves refresh
      next_strobe_n[s] = ~(refresh_i | (address_valid_i && subbank_enable[s] &&
                           set_match[s] && set_subbit[s] &&
                           next_hit_set == SET_W'(s)));
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hit_o <= 1'b0;
      refused_o <= 1'b0;
      hit_set_o <= '0;
      subbank_o <= 1'b0;
      subbank_row_strobe_n_o <= '1;
    end else if (ce_i) begin
      hit_o <= next_hit;
      refused_o <= next_refused;
      hit_set_o <= next_hit_set;
      subbank_o <= next_subbank;
      subbank_row_strobe_n_o <= next_strobe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB: no wait state; read data is registered in the setup cycle so it comes from a flop
  assign apb_write = psel_i & penable_i & pready_o & pwrite_i;

  always_comb begin
    next_pready = psel_i & ~penable_i;
    next_pslverr = 1'b0;
    next_prdata = '0;
    rd_kind = DBD_KIND_NONE;
    case (paddr_i)
      OFS_PD_LOW: begin
        rd_kind = DBD_KIND_MAP;
        next_prdata[PD_HALF-1:0] = pd_data[PD_HALF-1:0];
      end
      OFS_PD_HIGH: begin
        rd_kind = DBD_KIND_MAP;
        next_prdata[PD_HALF-1:0] = pd_data[PD_BITS-1:PD_HALF];
      end
      OFS_STATUS: begin
        rd_kind = DBD_KIND_MAP;
        next_prdata[STAT_PD_VALID_BIT] = pd_valid;
        next_prdata[STAT_HIT_BIT] = hit_o;
        next_prdata[STAT_SET_LSB +: SET_W] = hit_set_o;
      end
      default: begin
        for (int s = 0; s < NUM_SETS; s++) begin
          if (is_set_reg(paddr_i, OFS_SET_BASE0, s)) begin
            rd_kind = DBD_KIND_MAP;
            next_prdata[BASE_W-1:0] = set_base[s];
          end
          if (is_set_reg(paddr_i, OFS_SET_CFG0, s)) begin
            rd_kind = DBD_KIND_MAP;
            next_prdata[CFG_VALID_BIT] = set_valid[s];
            next_prdata[CFG_SIZE_LSB +: CFG_SIZE_W] = set_size_code[s];
            next_prdata[CFG_SUBENA_BIT] = subbank_enable[s];
          end
        end
      end
    endcase
    if (!next_pready || pwrite_i) begin
      next_prdata = '0;
    end
    if (next_pready && rd_kind == DBD_KIND_NONE) begin
      next_pslverr = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else if (ce_i) begin
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      prdata_o <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Config registers; only valid and subbank enable have reset values
  always_comb begin
    for (int s = 0; s < NUM_SETS; s++) begin
      next_set_valid[s] = set_valid[s];
      next_subbank_enable[s] = subbank_enable[s];
      next_set_size_code[s] = set_size_code[s];
      next_set_base[s] = set_base[s];
      if (apb_write && is_set_reg(paddr_i, OFS_SET_CFG0, s)) begin
        next_set_valid[s] = pwdata_i[CFG_VALID_BIT];
        next_subbank_enable[s] = pwdata_i[CFG_SUBENA_BIT];
        next_set_size_code[s] = pwdata_i[CFG_SIZE_LSB +: CFG_SIZE_W];
      end
      if (apb_write && is_set_reg(paddr_i, OFS_SET_BASE0, s)) begin
        next_set_base[s] = pwdata_i[BASE_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        set_valid[s] <= CFG_VALID_RST;
        subbank_enable[s] <= CFG_SUBENA_RST;
      end
    end else if (ce_i) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        set_valid[s] <= next_set_valid[s];
        subbank_enable[s] <= next_subbank_enable[s];
      end
    end
  end

  // Size and base are deliberately left without reset
  always_ff @(posedge ref_clk_i) begin
    if (ce_i) begin
      for (int s = 0; s < NUM_SETS; s++) begin
        set_size_code[s] <= next_set_size_code[s];
        set_base[s] <= next_set_base[s];
      end
    end
  end
endmodule // dbd_decode

/* verification/dbd_decode_asserts.sv */
// Port assertions of the bankset decode block
`timescale 1ns/10ps
module dbd_decode_asserts (
  // Clock, reset, APB
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Decode
  input wire logic address_valid_i,
  input wire logic refresh_i,
  input wire logic hit_o,
  input wire logic refused_o,
  input wire logic [dbd_pkg::SET_W-1:0] hit_set_o,
  input wire logic subbank_o,
  input wire logic [dbd_pkg::NUM_SETS-1:0] subbank_row_strobe_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  ready_after_setup_a: assert property (
    psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
  err_with_ready_a: assert property (
    pslverr_o |-> pready_o) else $error("error without ready");
  decode_answer_a: assert property (
    address_valid_i |=> hit_o != refused_o) else $error("hit and refused agree");
  result_hold_a: assert property (
    !address_valid_i |=> $stable(hit_o) && $stable(hit_set_o) && $stable(subbank_o))
    else $error("decode result moved without address");
  miss_clean_a: assert property (
    refused_o |-> hit_set_o == 0 && !subbank_o) else $error("miss carries set");
  sub_needs_hit_a: assert property (
    subbank_o |-> hit_o) else $error("subbank without hit");
  refresh_strobe_a: assert property (
    refresh_i |=> subbank_row_strobe_n_o == 8'h00) else $error("refresh strobes missing");
  strobe_match_a: assert property (
    !refresh_i |=> subbank_row_strobe_n_o == 8'hFF || $past(address_valid_i) && subbank_o
    && subbank_row_strobe_n_o == 8'(~(8'h01 << hit_set_o))) else $error("stray strobe");
endmodule // dbd_decode_asserts
bind dbd_decode dbd_decode_asserts u_asserts (.ref_clk_i, .reset_n_i, .psel_i, .penable_i,
  .pready_o, .pslverr_o, .address_valid_i, .refresh_i, .hit_o, .refused_o, .hit_set_o,
  .subbank_o, .subbank_row_strobe_n_o);

/* verification/dbd_bank_model.sv */
// Bankset memory stand-in counting subbank row activations
`timescale 1ns/10ps
module dbd_bank_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Memory side
  input wire logic [7:0] row_strobe_n_i,
  output int act_cnt_o
);
  // All strobes low is a refresh, not an access
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) act_cnt_o <= 0;
    else if ($countones(~row_strobe_n_i) == 1) act_cnt_o <= act_cnt_o + 1;
  end
endmodule // dbd_bank_model

/* verification/dbd_decode_tb_top.sv */
// Self-checking bench of the bankset decode block
`timescale 1ns/10ps
module dbd_decode_tb_top;
  import dbd_pkg::*;
  logic ref_clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic address_valid_i = 0, refresh_i = 0, pready_o, pslverr_o, hit_o, refused_o, subbank_o;
  logic [ADDR_W-1:0] paddr_i = 0;
  logic [DATA_W-1:0] pwdata_i = 0, prdata_o;
  logic [PHYS_ADDR_W-1:0] system_bus_address_i = 0;
  logic [SET_W-1:0] hit_set_o;
  logic [NUM_SETS-1:0] subbank_row_strobe_n_o;
  int miscompares = 0, checks = 0, acts = 0, act_cnt;
  logic presence_pin = 0;
  logic [31:0] pd_word = 0;
  int pd_edge = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  // Serial presence source; restarts its word with every reset
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      pd_edge <= 0;
      presence_pin <= pd_word[0];
    end else begin
      pd_edge <= pd_edge + 1;
      presence_pin <= pd_word[5'(pd_edge + 1)];
    end
  end
  dbd_decode DUT (.ref_clk_i, .reset_n_i, .ce_i(1'b1), .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pready_o, .pslverr_o, .prdata_o, .address_valid_i, .system_bus_address_i,
    .refresh_i, .hit_o, .refused_o, .hit_set_o, .subbank_o, .subbank_row_strobe_n_o,
    .presence_serial_i(presence_pin));
  dbd_bank_model BANK (.ref_clk_i, .reset_n_i, .row_strobe_n_i(subbank_row_strobe_n_o),
    .act_cnt_o(act_cnt));
  //////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    if (pready_o !== 1'b1) begin
      miscompares++;
      results();
    end
    @(posedge ref_clk_i);
  endtask
  // Sync stages still hold reset zeros for the first two bit times
  function automatic logic [31:0] pd_expect(input logic [31:0] w);
    pd_expect = w << 2;
  endfunction
  // Presence registers against the word the source shifted in
  task automatic presence_check();
    logic [31:0] r;
    logic [31:0] x;
    logic e;
    x = pd_expect(pd_word);
    apb(OFS_PD_LOW, 0, 0, r, e);
    cmp("pd_low", {16'h0, x[15:0]}, r);
    apb(OFS_PD_HIGH, 0, 0, r, e);
    cmp("pd_high", {16'h0, x[31:16]}, r);
    apb(OFS_STATUS, 0, 0, r, e);
    cmp("pd_valid", 1, r[STAT_PD_VALID_BIT]);
  endtask
  // One address beat, result checked in the cycle after it
  task automatic probe(input logic [33:0] a, input logic [10:0] b, input logic [3:0] s,
                       input logic se, input logic [2:0] k, input logic v);
    logic h, t;
    h = v && (((a[33:23] ^ b) >> (7 - s)) == 0);
    t = h & se & a[29 - s];
    acts += t;
    system_bus_address_i <= a;
    address_valid_i <= 1;
    @(posedge ref_clk_i);
    address_valid_i <= 0;
    #1;
    cmp("hit", h, hit_o);
    cmp("refused", !h, refused_o);
    cmp("set", h ? k : 3'h0, hit_set_o);
    cmp("subbank", t, subbank_o);
    cmp("strobe", t ? 8'(~(8'h01 << k)) : 8'hFF, subbank_row_strobe_n_o);
    @(posedge ref_clk_i);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic e, se;
    logic [10:0] b;
    logic [3:0] s;
    logic [2:0] k;
    logic [33:0] ah;
    void'($urandom(32'h4FF0));
    pd_word = $urandom;
    repeat (10) @(posedge ref_clk_i);
    reset_n_i <= 1;
    @(posedge ref_clk_i);
    apb(OFS_STATUS, 0, 0, r, e);
    cmp("pd_valid_early", 0, r[STAT_PD_VALID_BIT]);
    apb(OFS_SET_CFG0 + SET_STRIDE * 3'h7, 0, 0, r, e);
    cmp("cfg_reset", 0, r & 32'h21);
    apb(12'hFFC, 0, 0, r, e);
    cmp("unmapped_err", 1, e);
    cmp("unmapped_data", 0, r);
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      k = 3'($urandom);
      s = 4'($urandom_range(7, 1));
      se = 1'($urandom);
      b = 11'($urandom) & (11'h7FF << (7 - s));
      ah = {b, 23'h0} | (34'({$urandom, $urandom}) & ((34'h1 << (30 - s)) - 1));
      apb(OFS_SET_BASE0 + SET_STRIDE * k, 1, {21'h0, b}, r, e);
      apb(OFS_SET_BASE0 + SET_STRIDE * k, 0, 0, r, e);
      cmp("base", {21'h0, b}, r);
      apb(OFS_SET_CFG0 + SET_STRIDE * k, 1, {26'h0, se, s, 1'b1}, r, e);
      probe(ah, b, s, se, k, 1);
      probe(34'({$urandom, $urandom}), b, s, se, k, 1);
      apb(OFS_SET_CFG0 + SET_STRIDE * k, 1, {26'h0, se, s, 1'b0}, r, e);
      probe(ah, b, s, se, k, 0);
    end
    $display("test decode done");
    // Two sets cover one address; the lower index wins
    ah = {11'h200, 23'h0} | 34'h0_0040_0000;
    apb(OFS_SET_BASE0 + SET_STRIDE * 3'h4, 1, 32'h0000_0200, r, e);
    apb(OFS_SET_CFG0 + SET_STRIDE * 3'h4, 1, 32'h0000_002F, r, e);
    apb(OFS_SET_BASE0 + SET_STRIDE * 3'h1, 1, 32'h0000_0200, r, e);
    apb(OFS_SET_CFG0 + SET_STRIDE * 3'h1, 1, 32'h0000_0003, r, e);
    probe(ah, 11'h200, 4'h1, 1'b0, 3'h1, 1'b1);
    apb(OFS_STATUS, 0, 0, r, e);
    cmp("status_hit", 4'h3, r[4:1]);
    apb(OFS_SET_CFG0 + SET_STRIDE * 3'h1, 1, 32'h0000_0002, r, e);
    probe(ah, 11'h200, 4'h7, 1'b1, 3'h4, 1'b1);
    $display("test corner done");
    refresh_i <= 1;
    @(posedge ref_clk_i);
    refresh_i <= 0;
    #1;
    cmp("refresh", 8'h00, subbank_row_strobe_n_o);
    @(posedge ref_clk_i);
    cmp("activations", acts, act_cnt);
    presence_check();
    $display("test presence done");
    // Reset in mid-run with a fresh presence word on the pin
    reset_n_i <= 0;
    pd_word <= $urandom;
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1;
    @(posedge ref_clk_i);
    apb(OFS_STATUS, 0, 0, r, e);
    cmp("pd_valid_again", 0, r[STAT_PD_VALID_BIT]);
    apb(OFS_SET_CFG0 + SET_STRIDE * 3'h4, 0, 0, r, e);
    cmp("cfg_reset_again", 0, r & 32'h21);
    probe(ah, 11'h200, 4'h7, 1'b1, 3'h4, 1'b0);
    repeat (150) @(posedge ref_clk_i);
    presence_check();
    $display("test second reset done");
    results();
  end
endmodule // dbd_decode_tb_top
